// *** src/absbus_defines.vh ***
// Constants for the asynchronous sized bus master
`ifndef ABSBUS_DEFINES_VH
`define ABSBUS_DEFINES_VH
// Remaining-byte size encodings {hi, lo}
`define ABS_SIZE_BYTE  2'h1
`define ABS_SIZE_WORD  2'h2
`define ABS_SIZE_THREE 2'h3
`define ABS_SIZE_LONG  2'h0
// Request operand sizes
`define ABS_OP_BYTE    2'h0
`define ABS_OP_WORD    2'h1
`define ABS_OP_LONG    2'h2
// Acknowledge pair decode {hi_n, lo_n}
`define ABS_ACK_WAIT   2'h3
`define ABS_ACK_8BIT   2'h2
`define ABS_ACK_16BIT  2'h1
`define ABS_ACK_RSVD   2'h0
// Bus monitor timeout in cycles
`define ABS_MON_CYCLES 16'h0040
`endif

// *** src/absbus_master.v ***
// Asynchronous 16-bit bus master with dynamic sizing and cycle termination
`timescale 1ns/1ps
`include "absbus_defines.vh"

// Summary of operation
// - Read cycles assert data strobe together with address strobe.
// - Write cycles assert data strobe one clock after address strobe.
// - Read ends on port acknowledge; master latches data then terminates.
// - Acknowledge pair: wait, 8-bit, 16-bit, or reserved.
// - Bus fault terminates alone or together with acknowledges.
// - Bus fault with hold asserted gives a bus error exception.
// - Internal bus monitor can raise the bus fault termination.
// - Autovector ends only interrupt acknowledge cycles; ignored otherwise.
// - Autovector held asserted autovectors every interrupt acknowledge.
// - Long word: two 16-bit cycles or four byte cycles.
// - Assume 16-bit port first; add cycles only for narrower ports.
// - Operand bytes ordered most significant first.
// - Size outputs give bytes still to transfer.
// - Upper address carries word base, lowest bit byte offset.
// - Byte lanes routed from size outputs and lowest address bit.
// - Odd-address word and long operands are rejected.
// - At most one aligned word per cycle, most significant first.
// - Size codes: 01 byte, 10 word, 11 three, 00 long.
// - Address strobe asserted on the same clock as the address outputs; outputs stable meanwhile.
// - Read data captured on the last falling edge of the cycle.
module absbus_master #(
	parameter MON_CYCLES = `ABS_MON_CYCLES
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        srst,
	// Operand request
	input  wire        reqValid,
	input  wire        reqWrite,
	input  wire        reqIntAck,
	input  wire        reqInternal,
	input  wire [1:0]  reqSize,
	input  wire [23:0] reqAddr,
	input  wire [31:0] reqWdata,
	output reg         reqReady,
	output reg         doneValid,
	output reg  [31:0] doneRdata,
	output reg         doneBusErr,
	output reg         doneAutoVec,
	output reg         doneMisalign,
	output reg         busErrExcept,
	// External bus
	output reg  [23:1] addrWord,
	output reg         byte_lane_offset,
	output reg         remaining_bytes_hi,
	output reg         remaining_bytes_lo,
	output reg         readNotWrite,
	output reg         address_strobe_n,
	output reg         data_strobe_n,
	output reg  [15:0] dataOut,
	output reg         dataOe,
	input  wire [15:0] dataIn,
	input  wire        port_ack_hi_n,
	input  wire        port_ack_lo_n,
	input  wire        bus_fault_n,
	input  wire        auto_vector_ack_n,
	input  wire        holdReq_n
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_WAIT  = 3'h2;
	localparam ST_END   = 3'h3;
	localparam ST_DONE  = 3'h4;

	// Three-stage synchronisers for asynchronous inputs
	// Pin changes reach inSt some four clocks after they happen
	wire [4:0] rawIn = {holdReq_n, auto_vector_ack_n, bus_fault_n,
		port_ack_lo_n, port_ack_hi_n};
	wire [4:0] inSt;

	absbus_sync #(
		.WIDTH    (5)
	) i_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.rawIn    (rawIn),
		.stable   (inSt)
	);

	wire ackHiN   = inSt[0];
	wire ackLoN   = inSt[1];
	wire faultN   = inSt[2];
	wire avecN    = inSt[3];
	wire holdN    = inSt[4];
	// Acknowledge and fault pins negated (autovector not included); the synchronised view lags the slave,
	// so a new cycle must wait for it or a stale acknowledge ends it at once
	wire busFree  = ackHiN & ackLoN & faultN;

	reg  [2:0]  state_r;
	reg  [2:0]  remain_r;
	reg  [23:0] curAddr_r;
	reg  [31:0] opData_r;
	reg  [31:0] rdAcc_r;
	reg  [15:0] monCnt_r;
	reg         monFault_r;
	reg         dsPend_r;
	reg         isIack_r;
	reg         fallSample_r;
	reg  [15:0] fallData_r;

	// Bus monitor raises an internal fault when no termination comes in a reqInternal cycle
	// bus monitor
	wire monFire = (monCnt_r == MON_CYCLES[15:0]);
	wire faultTerm = ~faultN | monFault_r;
	wire [1:0] ackPair = {ackHiN, ackLoN};
	wire ack8  = (ackPair == `ABS_ACK_8BIT);
	wire ack16 = (ackPair == `ABS_ACK_16BIT);
	wire avecTerm = isIack_r & ~avecN;
	wire anyTerm = faultTerm | ack8 | ack16 | avecTerm;

	// capture on falling edge so the last falling edge holds the data
	always @(negedge core_clk) begin
		if (srst) begin
			fallData_r <= 16'h0000;
		end else if (~address_strobe_n) begin
			fallData_r <= dataIn;
		end
	end

	// size code from remaining byte count
	function [1:0] sizeCode;
		input [2:0] n;
		begin
			case (n)
				3'h1:    sizeCode = `ABS_SIZE_BYTE;
				3'h2:    sizeCode = `ABS_SIZE_WORD;
				3'h3:    sizeCode = `ABS_SIZE_THREE;
				default: sizeCode = `ABS_SIZE_LONG;
			endcase
		end
	endfunction

	// Bytes moved this cycle: one on 8-bit port, odd address or single byte left, else two
	wire       wide     = ack16 & ~curAddr_r[0] & (remain_r != 3'h1);
	wire [2:0] moved    = wide ? 3'h2 : 3'h1;
	wire [2:0] remNext  = remain_r - moved;
	// next byte to go is the top byte of what remains
	wire [7:0] topByte  = opData_r[31:24];
	// 8-bit port data arrives on lines 15:8
	wire [7:0] rdByte   = (ack16 & curAddr_r[0]) ? fallData_r[7:0] : fallData_r[15:8];

	always @(posedge core_clk) begin
		if (srst) begin
			state_r            <= ST_IDLE;
			remain_r           <= 3'h0;
			curAddr_r          <= 24'h000000;
			opData_r           <= 32'h00000000;
			rdAcc_r            <= 32'h00000000;
			monCnt_r           <= 16'h0000;
			monFault_r         <= 1'b0;
			dsPend_r           <= 1'b0;
			isIack_r           <= 1'b0;
			fallSample_r       <= 1'b0;
			reqReady           <= 1'b0;
			doneValid          <= 1'b0;
			doneRdata          <= 32'h00000000;
			doneBusErr         <= 1'b0;
			doneAutoVec        <= 1'b0;
			doneMisalign       <= 1'b0;
			busErrExcept       <= 1'b0;
			addrWord           <= 23'h000000;
			byte_lane_offset   <= 1'b0;
			remaining_bytes_hi <= 1'b0;
			remaining_bytes_lo <= 1'b0;
			readNotWrite       <= 1'b1;
			address_strobe_n   <= 1'b1;
			data_strobe_n      <= 1'b1;
			dataOut            <= 16'h0000;
			dataOe             <= 1'b0;
		end else begin
			doneValid    <= 1'b0;
			busErrExcept <= 1'b0;
			fallSample_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					// Accept work only once the previous slave has let go
					reqReady <= busFree;
					if (reqValid & reqReady) begin
						reqReady <= 1'b0;
						// reject odd word and long operands
						if (reqAddr[0] & (reqSize != `ABS_OP_BYTE)) begin
							doneValid    <= 1'b1;
							doneMisalign <= 1'b1;
							doneBusErr   <= 1'b0;
							doneAutoVec  <= 1'b0;
						end else begin
							remain_r  <= (reqSize == `ABS_OP_LONG) ? 3'h4 :
								(reqSize == `ABS_OP_WORD) ? 3'h2 : 3'h1;
							opData_r  <= (reqSize == `ABS_OP_LONG) ? reqWdata :
								(reqSize == `ABS_OP_WORD) ? {reqWdata[15:0], 16'h0000} :
								{reqWdata[7:0], 24'h000000};
							curAddr_r    <= reqAddr;
							rdAcc_r      <= 32'h00000000;
							readNotWrite <= ~reqWrite;
							isIack_r     <= reqIntAck;
							monFault_r   <= 1'b0;
							monCnt_r     <= 16'h0000;
							dsPend_r     <= reqInternal;
							state_r      <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					// Next portion waits until the last termination is released
					if (busFree) begin
						addrWord         <= curAddr_r[23:1];
						byte_lane_offset <= curAddr_r[0];
						// size outputs show bytes still to go
						{remaining_bytes_hi, remaining_bytes_lo} <= sizeCode(remain_r);
						// write lanes: odd or last byte on both lanes, otherwise top two bytes
						dataOut <= curAddr_r[0] ? {topByte, topByte} :
							(remain_r == 3'h1) ? {topByte, topByte} : opData_r[31:16];
						dataOe  <= ~readNotWrite;
						address_strobe_n <= 1'b0;
						// read data strobe with address strobe
						data_strobe_n    <= ~readNotWrite;
						monCnt_r         <= 16'h0000;
						state_r          <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// write data strobe one clock after address strobe
					if (~readNotWrite)
						data_strobe_n <= 1'b0;
					if (~monFault_r)
						monCnt_r <= monCnt_r + 16'h0001;
					if (monFire & dsPend_r)
						monFault_r <= 1'b1;
					if (anyTerm & ~(~readNotWrite & data_strobe_n)) begin
						fallSample_r <= 1'b1;
						state_r      <= ST_END;
					end
				end
				ST_END: begin
					// terminate and latch the portion just read
					address_strobe_n <= 1'b1;
					data_strobe_n    <= 1'b1;
					dataOe           <= 1'b0;
					if (faultTerm | avecTerm) begin
						doneBusErr   <= faultTerm;
						// autovector on every acknowledge while held
						doneAutoVec  <= ~faultTerm & avecTerm;
						// fault with hold raises the exception
						busErrExcept <= faultTerm & ~holdN;
						doneMisalign <= 1'b0;
						doneRdata    <= rdAcc_r;
						state_r      <= ST_DONE;
					end else begin
						// shift consumed bytes, next cycle if any remain
						if (wide) begin
							rdAcc_r  <= {rdAcc_r[15:0], fallData_r};
							opData_r <= {opData_r[15:0], 16'h0000};
						end else begin
							rdAcc_r  <= {rdAcc_r[23:0], rdByte};
							opData_r <= {opData_r[23:0], 8'h00};
						end
						remain_r  <= remNext;
						curAddr_r <= curAddr_r + {21'h000000, moved};
						if (remNext == 3'h0) begin
							doneRdata    <= wide ? {rdAcc_r[15:0], fallData_r} :
								{rdAcc_r[23:0], rdByte};
							doneBusErr   <= 1'b0;
							doneAutoVec  <= 1'b0;
							doneMisalign <= 1'b0;
							state_r      <= ST_DONE;
						end else begin
							state_r <= ST_ADDR;
						end
					end
				end
				ST_DONE: begin
					doneValid <= 1'b1;
					state_r   <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// Three-flop synchroniser for pins that change outside the clock domain
// A pin change shows at the output four clocks later; the master's wait
// states and its release wait both absorb that latency
module absbus_sync #(
	parameter WIDTH = 5
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             srst,
	// Raw pins in, filtered levels out
	input  wire [WIDTH-1:0] rawIn,
	output wire [WIDTH-1:0] stable
);

	reg  [WIDTH-1:0] sync1_r;
	reg  [WIDTH-1:0] sync2_r;
	reg  [WIDTH-1:0] sync3_r;
	reg  [WIDTH-1:0] level_r;

	// Bits whose last two stages agree may take the new level
	wire [WIDTH-1:0] agree = ~(sync2_r ^ sync3_r);

	// All pins are active low, so reset to the idle high level
	always @(posedge core_clk) begin
		if (srst) begin
			sync1_r <= {WIDTH{1'b1}};
			sync2_r <= {WIDTH{1'b1}};
			sync3_r <= {WIDTH{1'b1}};
			level_r <= {WIDTH{1'b1}};
		end else begin
			// Only the second stage reads the first
			sync1_r <= rawIn;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			// A one-cycle glitch never reaches the filtered level
			level_r <= (level_r & ~agree) | (sync3_r & agree);
		end
	end

	assign stable = level_r;

endmodule

// *** tb/absbus_chk.sv ***
// Assertion checker for the sized bus master
`timescale 1ns/1ps
`include "absbus_defines.vh"
module absbus_chk (
	// Clock, request and completion
	input wire        core_clk, srst, reqValid, reqReady, reqIntAck, reqInternal,
	input wire [1:0]  reqSize,
	input wire [23:0] reqAddr,
	input wire        doneValid, doneBusErr, doneAutoVec, doneMisalign, busErrExcept,
	// External bus
	input wire [23:1] addrWord,
	input wire        byte_lane_offset, remaining_bytes_hi, remaining_bytes_lo, readNotWrite,
	input wire        address_strobe_n, data_strobe_n, dataOe,
	input wire        port_ack_hi_n, port_ack_lo_n, bus_fault_n, auto_vector_ack_n
);
	reg [1:0] tkSize_r;
	reg       tkOff_r, tkInt_r, tkIack_r;
	wire      take = reqValid && reqReady;
	wire      bad = reqAddr[0] && reqSize != `ABS_OP_BYTE;
	wire      quiet = port_ack_hi_n && port_ack_lo_n && bus_fault_n && auto_vector_ack_n;
	wire [1:0] expSz = (tkSize_r == `ABS_OP_BYTE) ? `ABS_SIZE_BYTE :
		(tkSize_r == `ABS_OP_WORD) ? `ABS_SIZE_WORD : `ABS_SIZE_LONG;
	always @(posedge core_clk) begin
		if (take) begin
			tkSize_r <= reqSize;
			tkOff_r <= reqAddr[0];
			tkInt_r <= reqInternal;
			tkIack_r <= reqIntAck;
		end
	end
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (srst);
	a_read_ds_early:
	assert property ($fell(address_strobe_n) && readNotWrite |-> !data_strobe_n)
		else $error("read data strobe late");
	a_write_ds_late:
	assert property ($fell(address_strobe_n) && !readNotWrite |-> data_strobe_n ##1 !data_strobe_n)
		else $error("write data strobe timing");
	a_misalign_refused:
	assert property (take && bad |-> address_strobe_n throughout ##[1:3] (doneValid && doneMisalign))
		else $error("misaligned operand not refused");
	a_first_size:
	assert property (take && !bad |-> ##[1:3] ($fell(address_strobe_n)
		&& {remaining_bytes_hi, remaining_bytes_lo} == expSz && byte_lane_offset == tkOff_r))
		else $error("first cycle size or offset wrong");
	a_bus_stable:
	assert property (!address_strobe_n && !$fell(address_strobe_n) |->
		$stable({addrWord, byte_lane_offset, remaining_bytes_hi, remaining_bytes_lo, readNotWrite}))
		else $error("bus outputs moved in cycle");
	a_wait_hold:
	assert property ((quiet && !address_strobe_n && !tkInt_r) [*4] |=> !address_strobe_n)
		else $error("cycle ended without termination");
	a_fault_except:
	assert property (busErrExcept |-> ##[0:2] (doneValid && doneBusErr))
		else $error("exception without bus error");
	a_autovec_only:
	assert property (doneValid && doneAutoVec |-> tkIack_r)
		else $error("autovector outside acknowledge");
	a_write_drive:
	assert property (dataOe |-> !readNotWrite && !address_strobe_n)
		else $error("data bus driven outside a write cycle");
endmodule
bind absbus_master absbus_chk i_chk (
	.core_clk           (core_clk),
	.srst               (srst),
	.reqValid           (reqValid),
	.reqReady           (reqReady),
	.reqIntAck          (reqIntAck),
	.reqInternal        (reqInternal),
	.reqSize            (reqSize),
	.reqAddr            (reqAddr),
	.doneValid          (doneValid),
	.doneBusErr         (doneBusErr),
	.doneAutoVec        (doneAutoVec),
	.doneMisalign       (doneMisalign),
	.busErrExcept       (busErrExcept),
	.addrWord           (addrWord),
	.byte_lane_offset   (byte_lane_offset),
	.remaining_bytes_hi (remaining_bytes_hi),
	.remaining_bytes_lo (remaining_bytes_lo),
	.readNotWrite       (readNotWrite),
	.address_strobe_n   (address_strobe_n),
	.data_strobe_n      (data_strobe_n),
	.dataOe             (dataOe),
	.port_ack_hi_n      (port_ack_hi_n),
	.port_ack_lo_n      (port_ack_lo_n),
	.bus_fault_n        (bus_fault_n),
	.auto_vector_ack_n  (auto_vector_ack_n)
);

// *** tb/absbus_slave.sv ***
// Behavioural slave with port width, wait states and faults
`timescale 1ns/1ps
module absbus_slave (
	// Clock and test controls
	input wire         core_clk, port8, avecOn,
	input wire [1:0]   mode,
	input wire [3:0]   waitN,
	// Bus from the master
	input wire [23:1]  addrWord,
	input wire         byte_lane_offset, remaining_bytes_hi, remaining_bytes_lo, readNotWrite,
	input wire         address_strobe_n, data_strobe_n,
	input wire [15:0]  dataOut,
	// Answers
	output logic [15:0] dataIn = '0,
	output logic       port_ack_hi_n = '1, port_ack_lo_n = '1, bus_fault_n = '1,
	output wire        auto_vector_ack_n
);
	logic [7:0] mem [0:255];
	int         cnt = 0, nCyc = 0;
	wire [7:0]  a = {addrWord[7:1], byte_lane_offset};
	wire [7:0]  e = {addrWord[7:1], 1'b0};
	assign auto_vector_ack_n = !avecOn;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	always @(posedge core_clk) begin
		if (address_strobe_n) begin
			{port_ack_hi_n, port_ack_lo_n, bus_fault_n} <= 3'h7;
			cnt <= 0;
			dataIn <= ~dataIn;
		end else begin
			dataIn <= !readNotWrite ? ~dataIn : port8 ? {mem[a], ~mem[a]} : {mem[e], mem[e + 8'h01]};
			if (!data_strobe_n && cnt <= waitN) begin
				cnt <= cnt + 1;
				if (cnt == waitN) begin
					nCyc <= nCyc + 1;
					if (!readNotWrite && (port8 || {remaining_bytes_hi, remaining_bytes_lo} == 2'h1))
						mem[a] <= (port8 || !byte_lane_offset) ? dataOut[15:8] : dataOut[7:0];
					else if (!readNotWrite)
						{mem[e], mem[e + 8'h01]} <= dataOut;
					port_ack_hi_n <= !(mode[0] && !port8);
					port_ack_lo_n <= !(mode[0] && port8);
					bus_fault_n <= !mode[1];
				end
			end
		end
	end
endmodule

// *** tb/absbus_master_tb.sv ***
// Self-checking bench for the sized bus master
`timescale 1ns/1ps
module absbus_master_tb;
	logic core_clk = 0, srst = 1, reqValid = 0, reqWrite = 0, reqIntAck = 0, reqInternal = 0;
	logic holdReq_n = 1, port8 = 0, avecOn = 0;
	logic [1:0] reqSize = 0, mode = 1;
	logic [3:0] waitN = 0;
	logic [23:0] reqAddr = 0, ad;
	logic [31:0] reqWdata = 0, doneRdata, v, e, rd;
	logic reqReady, doneValid, doneBusErr, doneAutoVec, doneMisalign, busErrExcept, dataOe;
	logic byte_lane_offset, remaining_bytes_hi, remaining_bytes_lo, readNotWrite;
	logic address_strobe_n, data_strobe_n, port_ack_hi_n, port_ack_lo_n, bus_fault_n;
	logic auto_vector_ack_n, fBe, fAv, fMa;
	logic [23:1] addrWord;
	logic [15:0] dataOut, dataIn;
	integer seed = 32'h44C7;
	int err_count = 0, n_compared = 0, nExc = 0, c0, n;
	absbus_master #(.MON_CYCLES(8)) i_dut (.*);
	absbus_slave i_slv (.*);
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (busErrExcept === 1'b1) nExc <= nExc + 1;
	task automatic chk(string nm, logic [31:0] x, s);
		n_compared++;
		if (s !== x) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic op(logic w, logic [1:0] sz, logic [23:0] a, logic [31:0] d, logic ia, it);
		int k = 0;
		{reqValid, reqWrite, reqSize, reqAddr, reqWdata, reqIntAck, reqInternal} = {1'b1, w, sz, a, d, ia, it};
		while (reqReady !== 1'b1 && k < 50) @(posedge core_clk) #1 k++;
		if (reqReady !== 1'b1) begin
			err_count++;
			give_verdict;
		end
		@(posedge core_clk) #1 reqValid = 0;
		k = 0;
		while (doneValid !== 1'b1 && k < 500) @(posedge core_clk) #1 k++;
		if (k == 500) begin
			err_count++;
			give_verdict;
		end
		{rd, fBe, fAv, fMa} = {doneRdata, doneBusErr, doneAutoVec, doneMisalign};
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 srst = 0;
		for (int p = 0; p < 2; p++) for (int r = 0; r < 3; r++) for (int sz = 0; sz < 3; sz++) begin
			port8 = 1'(p);
			waitN = 4'($random(seed));
			v = $random(seed);
			ad = 24'($random(seed));
			ad[0] = ad[0] && sz == 0;
			n = sz == 2 ? 4 : sz + 1;
			e = n == 4 ? v : v & ((32'h1 << 8 * n) - 1);
			c0 = i_slv.nCyc;
			op(1, 2'(sz), ad, v, 0, 0);
			for (int i = 0; i < n; i++) chk("byte", e[8 * (n - 1 - i) +: 8], i_slv.mem[8'(ad + i)]);
			op(0, 2'(sz), ad, 0, 0, 0);
			chk("read data", e, rd);
			chk("cycles", 2 * (p ? n : (n + 1) / 2), i_slv.nCyc - c0);
		end
		$display("test sizing done");
		for (int sz = 1; sz < 3; sz++) begin
			c0 = i_slv.nCyc;
			op(0, 2'(sz), 24'h000013, 0, 0, 0);
			chk("misaligned", 1, fMa);
			chk("cycles", 0, i_slv.nCyc - c0);
		end
		$display("test misaligned done");
		for (int h = 0; h < 2; h++) begin
			mode = 2'(h + 2);
			holdReq_n = 1'(h);
			c0 = nExc;
			op(0, 1, 24'h000020, 0, 0, 0);
			chk("bus error", 1, fBe);
			chk("exception", 1 - h, nExc - c0);
		end
		mode = 0;
		holdReq_n = 1;
		op(0, 0, 24'h000021, 0, 0, 1);
		chk("monitor error", 1, fBe);
		$display("test faults done");
		avecOn = 1;
		mode = 1;
		op(1, 1, 24'h000020, 32'h0000BEEF, 0, 0);
		op(0, 1, 24'h000020, 0, 0, 0);
		chk("autovector", 0, fAv);
		chk("read data", 32'h0000BEEF, rd);
		mode = 0;
		repeat (2) begin
			op(0, 0, 24'h00000F, 0, 1, 0);
			chk("autovector", 1, fAv);
		end
		$display("test autovector done");
		give_verdict;
	end
endmodule
